// [design/aws_map.vh]
// Register offsets, field positions, reset values and codes for the area wait select block
`ifndef AWS_MAP_VH
`define AWS_MAP_VH

// ==========================================================
// Register offsets (byte-wide registers, chosen offsets)
`define AWS_ADDR_W          2
`define AWS_OFF_WAIT_54     2'h0
`define AWS_OFF_WAIT_32     2'h1
`define AWS_OFF_ACC_STATE   2'h2
`define AWS_OFF_STATUS      2'h3

// ==========================================================
// Field positions
`define AWS_HI_WAIT_MSB     6
`define AWS_HI_WAIT_LSB     4
`define AWS_LO_WAIT_MSB     2
`define AWS_LO_WAIT_LSB     0
`define AWS_WAIT_MASK       8'h77
`define AWS_AST_MASK        8'h3C
`define AWS_AREA5_THREE_STATE_EN_BIT        5
`define AWS_AREA4_THREE_STATE_EN_BIT        4
`define AWS_AREA3_THREE_STATE_EN_BIT        3
`define AWS_AREA2_THREE_STATE_EN_BIT        2

// ==========================================================
// Reset values
`define AWS_WAIT_RST        8'h77
`define AWS_AST_RST         8'h3C
`define AWS_AREA_WAIT_RST   3'h7
`define AWS_CAS_LAT_RST     3'h4
`define AWS_CAS_BAD_RST     1'b1

// ==========================================================
// Codes
`define AWS_WAIT_NONE       3'h0
`define AWS_CAS_MAX_CODE    3'h3
`define AWS_CAS_LAT_STEP    3'h1

`endif

// [design/aws_area_wait.v]
// One area's wait-count selection from its field and its 3-state enable
`timescale 1ns/1ps
`include "aws_map.vh"

module aws_area_wait
(
    // Configuration
    input  wire [2:0] wait_field,
    input  wire       three_state_en,
    // Result
    output wire [2:0] wait_count
);

    // ==========================================================
    // Selection
    // Two-state space ignores the field entirely
    assign wait_count = three_state_en ? wait_field : `AWS_WAIT_NONE;

endmodule

// [design/aws_top.v]
// Area 5..2 wait-state select with register port and CAS latency output
`timescale 1ns/1ps
`include "aws_map.vh"

// Behaviour
// - Area 5 waits equal field when 3-state
// - Area 4 waits equal field when 3-state
// - Area 3 waits equal field when 3-state
// - Area 2 waits equal field when 3-state
// - Reserved bits read zero, ignore writes
// - Wait fields reset to all ones
// - Area 2 field gives CAS latency
// - CAS latency independent of access-state bit
// - CAS latency equals the low two code bits plus one
// - Access-state bit one selects 3-state space
module aws_top
(
    // Clock and reset
    input  wire       clk,
    input  wire       sys_rst,
    input  wire       clk_en,
    // Register port
    input  wire [1:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // Wait counts per area
    output reg  [2:0] area5_wait,
    output reg  [2:0] area4_wait,
    output reg  [2:0] area3_wait,
    output reg  [2:0] area2_wait,
    // Synchronous DRAM CAS latency for areas 2 to 5
    output reg  [2:0] sdram_cas_latency,
    output reg        cas_code_bad
);

    // ==========================================================
    // Usage notes
    // - All state freezes while clk_en is low, reset excepted.
    // - A write lands at the strobe edge; the outputs follow one edge later.
    // - Reads answer in the next cycle only; the data port is zero otherwise.
    // - The access-state enables live here as a plain register so that the
    //   block can stand alone; bits 7, 6, 1 and 0 read as zero.
    // - Latency codes 100 to 111 are not allowed; the low two bits still drive
    //   the latency output and the status flag is raised so that firmware can
    //   see its own mistake instead of a silently clipped latency.
    // - Reset leaves the area 2 field at 111, a prohibited latency code,
    //   so the flag reads one until firmware loads a legal code.
    // - No interlock exists against changing a field mid-access; the bus
    //   sequencer samples these outputs when it starts an access.
    // - The status index is read-only; writes to it are dropped.

    // ==========================================================
    // Register storage and next values
    reg  [7:0] wait_ctrl_areas_5_4_reg;
    reg  [7:0] wait_ctrl_areas_5_4_next;
    reg  [7:0] wait_ctrl_areas_3_2_reg;
    reg  [7:0] wait_ctrl_areas_3_2_next;
    reg  [7:0] access_state_ctrl_reg;
    reg  [7:0] access_state_ctrl_next;
    reg  [7:0] rdata_next;

    // Decoded strobes, already qualified by the clock enable
    wire       wr_wait_54;
    wire       wr_wait_32;
    wire       wr_acc_state;
    wire       rd_take;

    // Per-area fields, selections and the shared latency code
    wire [2:0] a5_field;
    wire [2:0] a4_field;
    wire [2:0] a3_field;
    wire [2:0] a2_field;
    wire [2:0] a5_n;
    wire [2:0] a4_n;
    wire [2:0] a3_n;
    wire [2:0] a2_n;
    wire [2:0] cas_code;
    wire [2:0] cas_latency_n;
    wire       cas_bad_n;

    // ==========================================================
    // Helper functions
    // Upper three-bit wait field of a byte register
    function [2:0] hi_field;
        input [7:0] r;
        begin
            hi_field = r[`AWS_HI_WAIT_MSB:`AWS_HI_WAIT_LSB];
        end
    endfunction

    // Lower three-bit wait field of a byte register
    function [2:0] lo_field;
        input [7:0] r;
        begin
            lo_field = r[`AWS_LO_WAIT_MSB:`AWS_LO_WAIT_LSB];
        end
    endfunction

    // Register index match for a strobe
    function addr_hit;
        input [1:0] a;
        input [1:0] off;
        begin
            addr_hit = (a == off);
        end
    endfunction

    // Keep only implemented bits; reserved ones stay zero
    function [7:0] keep_bits;
        input [7:0] d;
        input [7:0] mask;
        begin
            keep_bits = d & mask;
        end
    endfunction

    // Codes with the top bit set are prohibited for latency
    function cas_prohibited;
        input [2:0] code;
        begin
            cas_prohibited = (code > `AWS_CAS_MAX_CODE);
        end
    endfunction

    // Latency is the code plus one; only the low two bits count
    function [2:0] cas_latency_of;
        input [2:0] code;
        begin
            cas_latency_of = {1'b0, code[1:0]} + `AWS_CAS_LAT_STEP;
        end
    endfunction

    // ==========================================================
    // Strobe decode
    // The clock enable is folded in here so nothing moves while it is low
    assign wr_wait_54   = clk_en & reg_wr & addr_hit(reg_addr, `AWS_OFF_WAIT_54);
    assign wr_wait_32   = clk_en & reg_wr & addr_hit(reg_addr, `AWS_OFF_WAIT_32);
    assign wr_acc_state = clk_en & reg_wr & addr_hit(reg_addr, `AWS_OFF_ACC_STATE);
    // A write to the status index has no target and is dropped
    assign rd_take      = clk_en & reg_rd;

    // ==========================================================
    // Next register values; reserved positions masked off on write
    // Areas 5 and 4 wait fields
    always @*
    begin
        wait_ctrl_areas_5_4_next = wait_ctrl_areas_5_4_reg;
        if (wr_wait_54)
            wait_ctrl_areas_5_4_next = keep_bits(reg_wdata, `AWS_WAIT_MASK);
    end

    // Areas 3 and 2 wait fields; area 2 also carries the latency code
    always @*
    begin
        wait_ctrl_areas_3_2_next = wait_ctrl_areas_3_2_reg;
        if (wr_wait_32)
            wait_ctrl_areas_3_2_next = keep_bits(reg_wdata, `AWS_WAIT_MASK);
    end

    // Access-state enables; only bits 5 to 2 exist in this block
    always @*
    begin
        access_state_ctrl_next = access_state_ctrl_reg;
        if (wr_acc_state)
            access_state_ctrl_next = keep_bits(reg_wdata, `AWS_AST_MASK);
    end

    // ==========================================================
    // Register updates, synchronous reset
    // Wait fields start at all ones, seven waits everywhere
    // Reset wins over the clock enable so a frozen block still initialises
    always @(posedge clk)
    begin
        if (sys_rst)
            wait_ctrl_areas_5_4_reg <= `AWS_WAIT_RST;
        else
            wait_ctrl_areas_5_4_reg <= wait_ctrl_areas_5_4_next;
    end

    // Same reset for the lower pair of areas
    always @(posedge clk)
    begin
        if (sys_rst)
            wait_ctrl_areas_3_2_reg <= `AWS_WAIT_RST;
        else
            wait_ctrl_areas_3_2_reg <= wait_ctrl_areas_3_2_next;
    end

    // Access-state enables start as 3-state for all four areas
    // That makes the reset wait counts seven, matching the fields
    always @(posedge clk)
    begin
        if (sys_rst)
            access_state_ctrl_reg <= `AWS_AST_RST;
        else
            access_state_ctrl_reg <= access_state_ctrl_next;
    end

    // ==========================================================
    // Read mux; status bit 0 shows whether the latency code is legal
    always @*
    begin
        rdata_next = 8'h00;
        case (reg_addr)
            `AWS_OFF_WAIT_54:
                rdata_next = keep_bits(wait_ctrl_areas_5_4_reg, `AWS_WAIT_MASK);
            `AWS_OFF_WAIT_32:
                rdata_next = keep_bits(wait_ctrl_areas_3_2_reg, `AWS_WAIT_MASK);
            `AWS_OFF_ACC_STATE:
                rdata_next = keep_bits(access_state_ctrl_reg, `AWS_AST_MASK);
            `AWS_OFF_STATUS:
                rdata_next = {7'h00, cas_prohibited(cas_code)};
            default:
                rdata_next = 8'h00;
        endcase
    end

    // Data stands only in the cycle after the read strobe, zero otherwise
    // Zero between reads keeps a stale byte from looking like a fresh one
    always @(posedge clk)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (clk_en)
            reg_rdata <= rd_take ? rdata_next : 8'h00;
    end

    // ==========================================================
    // Per-area wait selection
    // Fields are split out once so each instance sees a plain net
    assign a5_field = hi_field(wait_ctrl_areas_5_4_reg);
    assign a4_field = lo_field(wait_ctrl_areas_5_4_reg);
    assign a3_field = hi_field(wait_ctrl_areas_3_2_reg);
    assign a2_field = lo_field(wait_ctrl_areas_3_2_reg);

    // Each area gates its own field with its own enable
    aws_area_wait u_a5
    (
        .wait_field     (a5_field),
        .three_state_en (access_state_ctrl_reg[`AWS_AREA5_THREE_STATE_EN_BIT]),
        .wait_count     (a5_n)
    );

    aws_area_wait u_a4
    (
        .wait_field     (a4_field),
        .three_state_en (access_state_ctrl_reg[`AWS_AREA4_THREE_STATE_EN_BIT]),
        .wait_count     (a4_n)
    );

    aws_area_wait u_a3
    (
        .wait_field     (a3_field),
        .three_state_en (access_state_ctrl_reg[`AWS_AREA3_THREE_STATE_EN_BIT]),
        .wait_count     (a3_n)
    );

    aws_area_wait u_a2
    (
        .wait_field     (a2_field),
        .three_state_en (access_state_ctrl_reg[`AWS_AREA2_THREE_STATE_EN_BIT]),
        .wait_count     (a2_n)
    );

    // ==========================================================
    // Shared latency code: the raw area 2 field, no access-state gating
    // Latency applies to areas 2 to 5 even while area 2 is 2-state
    assign cas_code      = a2_field;
    // A prohibited code still yields a latency; the flag tells software
    assign cas_latency_n = cas_latency_of(cas_code);
    assign cas_bad_n     = cas_prohibited(cas_code);

    // ==========================================================
    // Registered outputs, one cycle after the configuration changes
    // Area 5 wait count
    // Reset values match what the reset fields would select
    always @(posedge clk)
    begin
        if (sys_rst)
            area5_wait <= `AWS_AREA_WAIT_RST;
        else if (clk_en)
            area5_wait <= a5_n;
    end

    // Area 4 wait count
    // Registered so the sequencer never sees a half-written byte
    always @(posedge clk)
    begin
        if (sys_rst)
            area4_wait <= `AWS_AREA_WAIT_RST;
        else if (clk_en)
            area4_wait <= a4_n;
    end

    // Area 3 wait count
    // Follows its field only while the area is 3-state
    always @(posedge clk)
    begin
        if (sys_rst)
            area3_wait <= `AWS_AREA_WAIT_RST;
        else if (clk_en)
            area3_wait <= a3_n;
    end

    // Area 2 wait count
    // Shares its field with the latency code below
    always @(posedge clk)
    begin
        if (sys_rst)
            area2_wait <= `AWS_AREA_WAIT_RST;
        else if (clk_en)
            area2_wait <= a2_n;
    end

    // Latency for areas 2 to 5
    // Reset field 111 gives latency four from its low bits
    always @(posedge clk)
    begin
        if (sys_rst)
            sdram_cas_latency <= `AWS_CAS_LAT_RST;
        else if (clk_en)
            sdram_cas_latency <= cas_latency_n;
    end

    // Prohibited latency code flag
    // Raised from reset, since the reset field is itself prohibited
    always @(posedge clk)
    begin
        if (sys_rst)
            cas_code_bad <= `AWS_CAS_BAD_RST;
        else if (clk_en)
            cas_code_bad <= cas_bad_n;
    end

endmodule

// [tb/aws_top_assertions.sv]
// Port assertions for the area wait select block
`timescale 1ns/1ps
module aws_top_chk
(
    // Register port
    input wire       clk,
    input wire       sys_rst,
    input wire [1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // Results
    input wire [2:0] area5_wait,
    input wire [2:0] sdram_cas_latency,
    input wire       cas_code_bad
);
    // ========
    // Checks, all on one clock
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    rsv_bits_a: assert property (reg_rd && !reg_addr[1] |=> !reg_rdata[7] && !reg_rdata[3])
        else $error("reserved bit set");
    stat_rsv_a: assert property (reg_rd && reg_addr == 2'h3 |=> reg_rdata[7:1] == 7'h00)
        else $error("status bits set");
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data stuck");
    cas_lat_a: assert property (reg_wr && reg_addr == 2'h1 ##1 !reg_wr
        |-> ##1 sdram_cas_latency == 3'h1 + $past(reg_wdata[1:0], 2)) else $error("bad latency");
    bad_code_a: assert property (reg_wr && reg_addr == 2'h1 ##1 !reg_wr
        |-> ##1 cas_code_bad == $past(reg_wdata[2], 2)) else $error("bad code flag");
    cas_keep_a: assert property (reg_wr && reg_addr == 2'h2 |=> ##1 $stable(sdram_cas_latency))
        else $error("latency moved");
    two_state_a: assert property (reg_wr && reg_addr == 2'h2 && !reg_wdata[5] ##1 !reg_wr
        |-> ##1 area5_wait == 3'h0) else $error("waits in 2-state");
    cfg_hold_a: assert property (!reg_wr ##1 !reg_wr |=> $stable(area5_wait))
        else $error("wait moved");
endmodule
bind aws_top aws_top_chk i_chk (.*);

// [tb/aws_mem_model.sv]
// Far-side memory model: bus states per access
`timescale 1ns/1ps
module aws_mem_model
(
    // Wait count in, states out
    input  wire [2:0] wait_cnt,
    output wire [3:0] acc_states
);
    // Three base states plus inserted waits
    assign acc_states = {1'b0, wait_cnt} + 4'h3;
endmodule

// [tb/tb_aws_top.sv]
// Bench for the area wait select block
`timescale 1ns/1ps
module tb_aws_top;
    // ========
    // Signals; clock enable starts on
    reg        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, clk_en = 1'b1;
    reg  [1:0] reg_addr = 2'h0;
    reg  [7:0] reg_wdata = 8'h00;
    wire [7:0] reg_rdata;
    wire [2:0] area5_wait, area4_wait, area3_wait, area2_wait, sdram_cas_latency;
    wire       cas_code_bad;
    wire [3:0] acc;
    wire [11:0] waits = {area5_wait, area4_wait, area3_wait, area2_wait};
    integer    err_count = 0, checks = 0, v;
    aws_top i_dut (.*);
    aws_mem_model i_mem (.wait_cnt(area5_wait), .acc_states(acc));
    // 50 MHz clock
    initial forever #10 clk = ~clk;
    // Compare and count
    task chk(input [11:0] got, exp);
        checks = checks + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    // One strobe cycle; a read compares the data of the next cycle
    task bus(input w, input [1:0] a, input [7:0] d);
        @(posedge clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge clk);
        {reg_wr, reg_rd} <= 2'b00;
        #1 if (!w) chk(reg_rdata, d);
    endtask
    // Verdict
    task end_sim;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Scenarios
    initial
    begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        bus(1'b0, 2'h0, 8'h77);
        chk(waits, 12'hFFF);
        chk({cas_code_bad, sdram_cas_latency}, 12'h00C);
        bus(1'b0, 2'h1, 8'h77);
        bus(1'b0, 2'h2, 8'h3C);
        bus(1'b1, 2'h1, 8'hFF);
        bus(1'b0, 2'h1, 8'h77);
        for (v = 0; v < 8; v = v + 1)
        begin
            bus(1'b1, 2'h0, {2{1'b0, v[2:0]}});
            bus(1'b1, 2'h1, {2{1'b0, v[2:0]}});
            @(posedge clk);
            #1 chk(waits, {4{v[2:0]}});
            chk({cas_code_bad, sdram_cas_latency}, {v[2], 3'h1 + v[1:0]});
            chk(acc, v[3:0] + 4'h3);
            bus(1'b0, 2'h3, {7'h00, v[2]});
        end
        bus(1'b1, 2'h2, 8'hC3);
        bus(1'b0, 2'h2, 8'h00);
        chk(waits, 12'h000);
        chk(sdram_cas_latency, 12'h004);
        bus(1'b1, 2'h2, 8'h24);
        bus(1'b1, 2'h3, 8'h00);
        chk(waits, 12'hE07);
        bus(1'b0, 2'h3, 8'h01);
        @(posedge clk) clk_en <= 1'b0;
        bus(1'b1, 2'h0, 8'h00);
        @(posedge clk) clk_en <= 1'b1;
        bus(1'b0, 2'h0, 8'h77);
        chk(waits, 12'hE07);
        end_sim;
    end
endmodule
